// >>> inc/ee_defs.svh
// Constants shared by both ends of the serial EEPROM link.
// Assumes a single 125 MHz mclk on both ends.
`ifndef EE_DEFS_SVH
`define EE_DEFS_SVH
`define EE_CLK_NS      8
`define EE_SCL_NS      2500
`define EE_QTR_CYC     ((`EE_SCL_NS / 4 + `EE_CLK_NS - 1) / `EE_CLK_NS)
`define EE_TWR_NS      5000000
`define EE_TWR_CYC     (`EE_TWR_NS / `EE_CLK_NS)
`define EE_DEV_CODE    4'hA
`define EE_AW          11
`define EE_PAGE        16
`define EE_PAGE_BITS   4
`define EE_BYTE_BITS   4'h8
`endif

// >>> inc/ee_pkg.sv
// Types shared by both ends of the serial EEPROM link.
// Assumes ee_defs.svh is on the include path.
`include "ee_defs.svh"
package ee_pkg;
  typedef logic [`EE_AW-1:0] ee_ptr_t;
  typedef logic [7:0]        ee_byte_t;
  typedef enum logic [1:0] {EE_CMD_START, EE_CMD_STOP, EE_CMD_WRITE, EE_CMD_READ} ee_cmd_e;
  typedef enum {ST_IDLE, ST_ADDR, ST_WORD, ST_WDATA, ST_RDATA, ST_WAIT} ee_st_e;
  typedef enum {M_IDLE, M_START, M_STOP, M_BIT} ee_mst_e;
endpackage

// >>> inc/ee_if.sv
// Two-wire open-drain link between master and EEPROM slave.
// Resolves the wire levels from the drivers' enables.
`timescale 1ns/10ps
interface ee_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Wired-AND with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
  modport master (output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, input scl, sda);
  modport slave  (output s_sda_o, s_sda_oe, input scl, sda);
endinterface

// >>> core/ee_sync.sv
// Three-stage input synchroniser with agreement filter.
// Input is asynchronous to mclk.
`timescale 1ns/10ps
module ee_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q  <= INIT;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // Change counts only once stages two and three agree
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule // ee_sync

// >>> core/ee_slave.sv
// EEPROM slave end: protocol engine, page buffer, array, write cycle.
// Assumes the master drives the clock; no clock stretching here.
`timescale 1ns/10ps
`include "ee_defs.svh"
module ee_slave #(
  parameter int unsigned WR_CYC = `EE_TWR_CYC
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic wp,
  output logic      busy,
  ee_if.slave       bus
);
  import ee_pkg::*;

  // ----------------------------------------
  // Input sampling and bus conditions
  // ----------------------------------------
  logic scl_q;
  logic sda_q;
  logic wp_q;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  ee_sync #(.INIT(1'b1)) u_scl (.mclk(mclk), .sys_rst(sys_rst), .d(bus.scl), .q(scl_q));
  ee_sync #(.INIT(1'b1)) u_sda (.mclk(mclk), .sys_rst(sys_rst), .d(bus.sda), .q(sda_q));
  ee_sync #(.INIT(1'b0)) u_wp  (.mclk(mclk), .sys_rst(sys_rst), .d(wp),      .q(wp_q));

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end

  assign scl_rise  = scl_q & ~scl_d;
  assign scl_fall  = ~scl_q & scl_d;
  assign start_det = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_det  = scl_q & scl_d & ~sda_d & sda_q;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  ee_byte_t                 mem [0:(1 << `EE_AW) - 1];
  ee_byte_t                 pbuf [0:`EE_PAGE-1];
  logic [`EE_PAGE-1:0]      valid;
  logic [`EE_AW-`EE_PAGE_BITS-1:0] page;
  logic [`EE_PAGE_BITS:0]   pidx;
  logic [19:0]              timer;
  ee_st_e                   st;
  logic [3:0]               cnt;
  logic                     ack_ph;
  logic                     sda_low;
  ee_byte_t                 shreg;
  ee_byte_t                 txd;
  ee_ptr_t                  ptr;
  logic [2:0]               hi;
  logic                     rw;
  logic                     m_ack;
  logic                     buf_we;
  logic [`EE_PAGE_BITS-1:0] buf_idx;
  ee_byte_t                 buf_dat;
  ee_byte_t                 rd_byte;
  logic                     pb_we;
  logic                     mem_we;

  function automatic ee_ptr_t page_inc(input ee_ptr_t p);
    page_inc = {p[`EE_AW-1:`EE_PAGE_BITS], p[`EE_PAGE_BITS-1:0] + 4'h1};
  endfunction

  assign rd_byte = mem[ptr];
  assign pb_we   = ~busy & buf_we;
  assign mem_we  = busy & ~pidx[`EE_PAGE_BITS] & valid[pidx[`EE_PAGE_BITS-1:0]];

  // No reset on arrays; contents are undefined until written
  always_ff @(posedge mclk) begin
    if (pb_we) begin
      pbuf[buf_idx] <= buf_dat;
    end
    if (mem_we) begin
      mem[{page, pidx[`EE_PAGE_BITS-1:0]}] <= pbuf[pidx[`EE_PAGE_BITS-1:0]];
    end
  end

  // ----------------------------------------
  // Programming cycle
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      busy  <= 1'b0;
      valid <= '0;
      page  <= '0;
      pidx  <= '0;
      timer <= '0;
    end else if (!busy) begin
      if (stop_det && (|valid) && !wp_q) begin
        busy  <= 1'b1;
        page  <= ptr[`EE_AW-1:`EE_PAGE_BITS];
        pidx  <= '0;
        timer <= '0;
      end else if (stop_det) begin
        valid <= '0;
      end
      // Set after clear, so a byte landing with a clear is kept
      if (pb_we) begin
        valid[buf_idx] <= 1'b1;
      end
    end else if (!pidx[`EE_PAGE_BITS]) begin
      // One byte per mclk; whole page lands inside one busy window
      pidx <= pidx + 5'h01;
    end else if (timer == 20'(WR_CYC - 1)) begin
      busy  <= 1'b0;
      valid <= '0;
    end else begin
      timer <= timer + 20'h00001;
    end
  end

  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st      <= ST_IDLE;
      cnt     <= 4'h0;
      ack_ph  <= 1'b0;
      sda_low <= 1'b0;
      shreg   <= 8'h00;
      txd     <= 8'h00;
      ptr     <= '0;
      hi      <= 3'h0;
      rw      <= 1'b0;
      m_ack   <= 1'b0;
      buf_we  <= 1'b0;
      buf_idx <= '0;
      buf_dat <= 8'h00;
    end else begin
      buf_we <= 1'b0;
      if (start_det) begin
        st      <= ST_ADDR;
        cnt     <= 4'h0;
        ack_ph  <= 1'b0;
        sda_low <= 1'b0;
      end else if (stop_det) begin
        st      <= ST_IDLE;
        ack_ph  <= 1'b0;
        sda_low <= 1'b0;
      end else if (st != ST_IDLE && st != ST_WAIT) begin
        if (scl_rise) begin
          if (!ack_ph) begin
            shreg <= {shreg[6:0], sda_q};
            cnt   <= cnt + 4'h1;
          end else begin
            m_ack <= ~sda_q;
          end
        end else if (scl_fall) begin
          if (!ack_ph && cnt == `EE_BYTE_BITS) begin
            ack_ph <= 1'b1;
            case (st)
              ST_ADDR: begin
                // Busy array answers nothing, so polling sees no acknowledge
                if (shreg[7:4] == `EE_DEV_CODE && !busy) begin
                  sda_low <= 1'b1;
                  hi      <= shreg[3:1];
                  rw      <= shreg[0];
                end else begin
                  st <= ST_WAIT;
                end
              end
              ST_WORD: begin
                sda_low <= 1'b1;
                ptr     <= {hi, shreg};
              end
              ST_WDATA: begin
                if (wp_q) begin
                  st <= ST_WAIT;
                end else begin
                  sda_low <= 1'b1;
                  buf_we  <= 1'b1;
                  buf_idx <= ptr[`EE_PAGE_BITS-1:0];
                  buf_dat <= shreg;
                  ptr     <= page_inc(ptr);
                end
              end
              default: begin
                sda_low <= 1'b0;
              end
            endcase
          end else if (ack_ph) begin
            ack_ph <= 1'b0;
            cnt    <= 4'h0;
            case (st)
              ST_ADDR: begin
                if (rw) begin
                  st      <= ST_RDATA;
                  sda_low <= ~rd_byte[7];
                  txd     <= {rd_byte[6:0], 1'b0};
                  ptr     <= ptr + 11'h001;
                end else begin
                  st      <= ST_WORD;
                  sda_low <= 1'b0;
                end
              end
              ST_WORD: begin
                st      <= ST_WDATA;
                sda_low <= 1'b0;
              end
              ST_RDATA: begin
                if (m_ack) begin
                  sda_low <= ~rd_byte[7];
                  txd     <= {rd_byte[6:0], 1'b0};
                  ptr     <= ptr + 11'h001;
                end else begin
                  st      <= ST_WAIT;
                  sda_low <= 1'b0;
                end
              end
              default: begin
                sda_low <= 1'b0;
              end
            endcase
          end else if (st == ST_RDATA) begin
            sda_low <= ~txd[7];
            txd     <= {txd[6:0], 1'b0};
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Open-drain data driver
  // ----------------------------------------
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = sda_low;
endmodule // ee_slave

// >>> core/ee_master.sv
// Bus master end: byte-level START, STOP, write and read primitives.
// Assumes the user sequences commands into legal transfers.
`timescale 1ns/10ps
`include "ee_defs.svh"
module ee_master (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  ee_pkg::ee_cmd_e  cmd_op,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_ack,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic             rsp_ack,
  ee_if.master             bus
);
  import ee_pkg::*;

  // ----------------------------------------
  // Quarter-bit divider
  // ----------------------------------------
  localparam logic [7:0] QTR = 8'(`EE_QTR_CYC);
  ee_mst_e     st;
  logic [7:0]  qcnt;
  logic        tick;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic        rd;
  logic        mack;
  logic [7:0]  sh;
  logic [7:0]  rxd;
  logic        ackd;
  logic        scl_low;
  logic        sda_low;
  logic        sda_q;

  ee_sync #(.INIT(1'b1)) u_sda (.mclk(mclk), .sys_rst(sys_rst), .d(bus.sda), .q(sda_q));

  assign tick      = (qcnt == QTR - 8'h01);
  assign cmd_ready = (st == M_IDLE);

  always_ff @(posedge mclk) begin
    if (sys_rst || st == M_IDLE || tick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // ----------------------------------------
  // Bit sequencer
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st        <= M_IDLE;
      q         <= 2'h0;
      bitn      <= 4'h0;
      rd        <= 1'b0;
      mack      <= 1'b0;
      sh        <= 8'h00;
      rxd       <= 8'h00;
      ackd      <= 1'b0;
      scl_low   <= 1'b0;
      sda_low   <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_ack   <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (st == M_IDLE) begin
        if (cmd_valid) begin
          q    <= 2'h0;
          bitn <= 4'h0;
          sh   <= cmd_data;
          rd   <= (cmd_op == EE_CMD_READ);
          mack <= cmd_ack;
          case (cmd_op)
            EE_CMD_START: st <= M_START;
            EE_CMD_STOP:  st <= M_STOP;
            default:      st <= M_BIT;
          endcase
        end
      end else if (tick) begin
        q <= q + 2'h1;
        case (st)
          M_START: begin
            case (q)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                st      <= M_IDLE;
                rsp_valid <= 1'b1;
              end
            endcase
          end
          M_STOP: begin
            case (q)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default: begin
                st        <= M_IDLE;
                rsp_valid <= 1'b1;
              end
            endcase
          end
          default: begin
            case (q)
              2'h0: begin
                if (bitn < `EE_BYTE_BITS) begin
                  sda_low <= ~rd & ~sh[7];
                end else begin
                  sda_low <= rd & mack;
                end
              end
              2'h1: scl_low <= 1'b0;
              2'h2: begin
                if (bitn < `EE_BYTE_BITS) begin
                  rxd <= {rxd[6:0], sda_q};
                end else begin
                  ackd <= ~sda_q;
                end
              end
              default: begin
                scl_low <= 1'b1;
                sh      <= {sh[6:0], 1'b0};
                bitn    <= bitn + 4'h1;
                if (bitn == `EE_BYTE_BITS) begin
                  st        <= M_IDLE;
                  sda_low   <= 1'b0;
                  rsp_valid <= 1'b1;
                  rsp_data  <= rxd;
                  rsp_ack   <= ackd;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = scl_low;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = sda_low;
endmodule // ee_master

// >>> verification/ee_link_asserts.sv
// Protocol checker for the two-wire link between master and slave.
// Assumes instantiation beside the link interface, one mclk domain.
`timescale 1ns/10ps
module ee_link_asserts #(
  parameter int unsigned WR_CYC = 200
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic s_sda_oe,
  input wire logic wp,
  input wire logic busy
);
  int unsigned busy_cnt;

  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Counter instead of a long repetition, which tools unroll badly
  always_ff @(posedge mclk) begin
    if (sys_rst || !busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_start_quiet: assert property (s_start |-> !s_sda_oe [*8])
    else $error("slave pulls data at a start");
  a_stop_release: assert property (s_stop |-> !s_sda_oe [*8])
    else $error("slave pulls data at a stop");
  // Slack of 20 cycles covers the synchroniser lag after the clock fall
  a_drive_on_fall: assert property ($changed(s_sda_oe) |-> !scl && $past(scl, 20))
    else $error("slave data changed away from a clock fall");
  a_ack_hold: assert property ($rose(s_sda_oe) |=> s_sda_oe [*8])
    else $error("slave acknowledge too short");
  a_busy_quiet: assert property (busy |-> !s_sda_oe)
    else $error("slave drives data while programming");
  a_busy_after_stop: assert property ($rose(busy) |-> scl && sda)
    else $error("programming began without a stop");
  a_wp_no_prog: assert property (wp && $past(wp, 8) |-> !$rose(busy))
    else $error("programming began while protected");
  a_busy_span: assert property ($fell(busy) |-> busy_cnt >= WR_CYC && busy_cnt <= WR_CYC + 32)
    else $error("programming time out of range");
endmodule // ee_link_asserts

// >>> verification/test_i2c_eeprom_slave_access.sv
// Self-checking bench: master end drives slave end over the link.
// Assumes the ee_pkg package and link interface are compiled first.
`timescale 1ns/10ps
module test_i2c_eeprom_slave_access;
  import ee_pkg::*;
  localparam int unsigned WR_CYC = 3500;
  logic       mclk, sys_rst, wp, busy, cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack;
  logic [7:0] cmd_data, rsp_data;
  ee_cmd_e    cmd_op;
  int         err_count, total_checks;

  ee_if u_ee_if ();
  ee_slave #(.WR_CYC(WR_CYC)) u_ee_slave (.mclk(mclk), .sys_rst(sys_rst), .wp(wp), .busy(busy),
    .bus(u_ee_if.slave));
  ee_master u_ee_master (.mclk(mclk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_ack(rsp_ack), .bus(u_ee_if.master));
  ee_link_asserts #(.WR_CYC(WR_CYC)) u_ee_link_asserts (.mclk(mclk), .sys_rst(sys_rst), .scl(u_ee_if.scl),
    .sda(u_ee_if.sda), .s_sda_oe(u_ee_if.s_sda_oe), .wp(wp), .busy(busy));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------
  // Compare, access and report tasks
  // ----------------------------------------
  task automatic chk_bit(logic got, logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(logic [7:0] got, logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Ready is level from state, so seen at a falling edge it holds to the take
  task automatic run(ee_cmd_e op, logic [7:0] d, logic a);
    int n;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk_bit(rsp_valid, 1'b1);
  endtask
  task automatic start();
    run(EE_CMD_START, 8'h00, 1'b0);
  endtask
  task automatic stop();
    run(EE_CMD_STOP, 8'h00, 1'b0);
  endtask
  task automatic wr(logic [7:0] d, logic exp);
    run(EE_CMD_WRITE, d, 1'b0);
    chk_bit(rsp_ack, exp);
  endtask
  task automatic rd(logic a, logic [7:0] exp);
    run(EE_CMD_READ, 8'h00, a);
    chk_byte(rsp_data, exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk_bit(busy, 1'b0);
  endtask
  task automatic done(int t);
    $display("test %0d finished, mismatches so far %0d", t, err_count);
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Run needs about 82000 cycles; cut off at 95000
  initial begin
    #760000;
    err_count++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    wp = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = EE_CMD_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    err_count = 0;
    total_checks = 0;
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    // Byte write at 7FF, then poll while programming
    start();
    wr(8'hAE, 1'b1);
    wr(8'hFF, 1'b1);
    wr(8'h5A, 1'b1);
    stop();
    chk_bit(busy, 1'b1);
    start();
    wr(8'hA2, 1'b0);
    stop();
    wait_idle();
    start();
    wr(8'hA2, 1'b1);
    stop();
    done(1);
    // Page write from 00F; later bytes wrap to 000 and 001
    start();
    wr(8'hA0, 1'b1);
    wr(8'h0F, 1'b1);
    wr(8'h11, 1'b1);
    wr(8'h22, 1'b1);
    wr(8'h33, 1'b1);
    stop();
    wait_idle();
    done(2);
    // Random then sequential read from 7FF over the top into 000
    start();
    wr(8'hAE, 1'b1);
    wr(8'hFF, 1'b1);
    start();
    wr(8'hAF, 1'b1);
    rd(1'b1, 8'h5A);
    rd(1'b0, 8'h22);
    stop();
    done(3);
    // Current read goes on at 001
    start();
    wr(8'hA3, 1'b1);
    rd(1'b0, 8'h33);
    stop();
    done(4);
    // First page byte landed at 00F
    start();
    wr(8'hA0, 1'b1);
    wr(8'h0F, 1'b1);
    start();
    wr(8'hA1, 1'b1);
    rd(1'b0, 8'h11);
    stop();
    done(5);
    // Write protect refuses the data byte
    @(negedge mclk);
    wp = 1'b1;
    start();
    wr(8'hA0, 1'b1);
    wr(8'h00, 1'b1);
    wr(8'h99, 1'b0);
    stop();
    repeat (20) @(negedge mclk);
    chk_bit(busy, 1'b0);
    wp = 1'b0;
    done(6);
    // Foreign address is ignored, bus left idle high
    start();
    wr(8'h50, 1'b0);
    stop();
    chk_bit(u_ee_if.sda & u_ee_if.scl, 1'b1);
    done(7);
    summarize();
  end
endmodule // test_i2c_eeprom_slave_access
